// ### design/ssc_config_check.sv
// Start selector decode, power-up capture and configuration check
//
// Behaviour
// - Positions 1,2,5,6 manual/auto; 3,4,7,8 monitored
// - Startup test on for even positions
// - Dynamization on for positions 1 to 4
// - Incompatible start/application combination flags error
// - Selectors captured only at power-up
// - Mismatch with captured positions flags error
// - Any error from capture on forces safe state until power cycle
// - Startup test: inputs must drop then return
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_config_check
  import ssc_pkg::*;
#(
  parameter int POS_W = `SSC_POS_W,
  parameter int APP_W = `SSC_APP_W,
  parameter int SAFE_IN_N = `SSC_SAFE_IN_N,
  // Start function allowed per application: bit (app*8 + pos)
  parameter logic [(1<<`SSC_APP_W)*8-1:0] COMPAT = '1
) (
  // Clock and reset (reset is the power-on reset)
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Selectors: start position 0..7 means 1..8
  input wire logic [POS_W-1:0] i_start_sel,
  input wire logic [APP_W-1:0] i_app_sel,
  // Safety inputs and general errors from elsewhere
  input wire logic [SAFE_IN_N-1:0] i_safe_in,
  input wire logic i_other_err,
  // Decoded configuration
  output ssc_cfg_s o_cfg,
  output logic [APP_W-1:0] o_app_cfg,
  output logic o_cfg_valid,
  // Status
  output logic o_cfg_err,
  output logic o_safe_state,
  output logic o_startup_done
);
  // ----------------------------------------
  // State and capture
  // ----------------------------------------
  ssc_state_e state_reg;
  ssc_state_e state_next;
  logic [`SSC_CNT_W-1:0] cnt_reg;
  logic [`SSC_CNT_W-1:0] cnt_next;
  logic err_reg;
  logic err_next;
  logic [SAFE_IN_N-1:0] seen_off_reg;
  logic [SAFE_IN_N-1:0] seen_off_next;
  logic [SAFE_IN_N-1:0] back_on_reg;
  logic [SAFE_IN_N-1:0] back_on_next;
  ssc_cfg_s cfg_reg;
  ssc_cfg_s cfg_next;
  logic load;
  logic [POS_W-1:0] held_pos;
  logic [APP_W-1:0] held_app;
  logic mismatch;
  logic incompat;
  logic test_done;
  ssc_cfg_s dec;

  // Capture happens once, at the end of the settle window
  assign load = (state_reg == SSC_ST_SETTLE) && (cnt_reg == `SSC_CNT_W'(`SSC_SETTLE_CYC - 1));

  ssc_snap #(
    .POS_W(POS_W),
    .APP_W(APP_W)
  ) u_snap (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(load),
    .i_pos(i_start_sel),
    .i_app(i_app_sel),
    .o_pos(held_pos),
    .o_app(held_app)
  );

  // ----------------------------------------
  // Start selector decode
  // ----------------------------------------
  // Code k is position k+1; the full table keeps each position on one line
  always_comb begin
    dec = '0;
    case (i_start_sel)
      3'h0: dec = '{monitored: 1'b0, startup_test: 1'b0, dynamization: 1'b1};
      3'h1: dec = '{monitored: 1'b0, startup_test: 1'b1, dynamization: 1'b1};
      3'h2: dec = '{monitored: 1'b1, startup_test: 1'b0, dynamization: 1'b1};
      3'h3: dec = '{monitored: 1'b1, startup_test: 1'b1, dynamization: 1'b1};
      3'h4: dec = '{monitored: 1'b0, startup_test: 1'b0, dynamization: 1'b0};
      3'h5: dec = '{monitored: 1'b0, startup_test: 1'b1, dynamization: 1'b0};
      3'h6: dec = '{monitored: 1'b1, startup_test: 1'b0, dynamization: 1'b0};
      3'h7: dec = '{monitored: 1'b1, startup_test: 1'b1, dynamization: 1'b0};
      default: dec = '0;
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Compared every cycle after capture, so a knob turned under power is caught
  assign mismatch = (i_start_sel != held_pos) || (i_app_sel != held_app);
  assign incompat = !COMPAT[{i_app_sel, i_start_sel}];

  // Inputs already low at capture count as the first drop
  generate
    for (genvar g = 0; g < SAFE_IN_N; g++) begin : g_test
      always_comb begin
        seen_off_next[g] = seen_off_reg[g];
        back_on_next[g] = back_on_reg[g];
        if (state_reg == SSC_ST_SETTLE) begin
          seen_off_next[g] = 1'b0;
          back_on_next[g] = 1'b0;
        end else if (!i_safe_in[g]) begin
          seen_off_next[g] = 1'b1;
        end else if (seen_off_reg[g]) begin
          back_on_next[g] = 1'b1;
        end
      end
    end
  endgenerate

  assign test_done = !cfg_reg.startup_test || (&back_on_reg);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      seen_off_reg <= '0;
      back_on_reg <= '0;
    end else begin
      seen_off_reg <= seen_off_next;
      back_on_reg <= back_on_next;
    end
  end

  // ----------------------------------------
  // Sticky configuration error
  // ----------------------------------------
  // Set only; a knob turned back into place must not clear it
  always_comb begin
    err_next = err_reg;
    if (load && incompat) begin
      err_next = 1'b1;
    end
    // Watched in safe state too: a move is a configuration error in run and safe state alike, but not during settle
    if ((state_reg != SSC_ST_SETTLE) && mismatch) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cfg_next = cfg_reg;
    case (state_reg)
      SSC_ST_SETTLE: begin
        cnt_next = cnt_reg + `SSC_CNT_W'(1);
        if (load) begin
          // Decode is kept even for a refused combination
          cfg_next = dec;
          if (incompat) begin
            state_next = SSC_ST_SAFE;
          end else if (i_other_err) begin
            state_next = SSC_ST_SAFE;
          end else begin
            state_next = SSC_ST_RUN;
          end
        end
      end
      SSC_ST_RUN: begin
        if (mismatch) begin
          state_next = SSC_ST_SAFE;
        end else if (i_other_err) begin
          state_next = SSC_ST_SAFE;
        end
      end
      SSC_ST_SAFE: begin
        // No exit: only power-on reset leaves here
        state_next = SSC_ST_SAFE;
      end
      default: begin
        state_next = SSC_ST_SAFE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= SSC_ST_SETTLE;
      cnt_reg <= '0;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_cfg = cfg_reg;
  assign o_app_cfg = held_app;
  assign o_cfg_valid = (state_reg == SSC_ST_RUN);
  assign o_cfg_err = err_reg;
  // Outputs stay off until the startup test is through
  assign o_safe_state = (state_reg != SSC_ST_RUN) || !test_done;
  assign o_startup_done = test_done && (state_reg == SSC_ST_RUN);
endmodule // ssc_config_check

// ### shared/ssc_map.svh
// Constants for the start selector configuration check
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_POS_W 3
`define SSC_APP_W 4
`define SSC_SAFE_IN_N 2
`define SSC_SETTLE_NS 1000
`define SSC_SETTLE_CYC ((`SSC_SETTLE_NS + 3) / 4)
`define SSC_CNT_W 9
`define SSC_APP_RST 4'h0
`define SSC_POS_RST 3'h0
`endif

// ### shared/ssc_pkg.sv
// Types for the start selector configuration check
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_ST_SETTLE = 2'b00,
    SSC_ST_RUN = 2'b01,
    SSC_ST_SAFE = 2'b11
  } ssc_state_e;
  typedef struct packed {
    logic monitored;
    logic startup_test;
    logic dynamization;
  } ssc_cfg_s;
endpackage

// ### design/ssc_snap.sv
// Power-up capture register for the selector positions
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_snap
  import ssc_pkg::*;
#(
  parameter int POS_W = `SSC_POS_W,
  parameter int APP_W = `SSC_APP_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Capture
  input wire logic i_load,
  input wire logic [POS_W-1:0] i_pos,
  input wire logic [APP_W-1:0] i_app,
  // Held values
  output logic [POS_W-1:0] o_pos,
  output logic [APP_W-1:0] o_app
);
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  logic [APP_W-1:0] app_reg;
  logic [APP_W-1:0] app_next;

  always_comb begin
    pos_next = pos_reg;
    app_next = app_reg;
    if (i_load) begin
      pos_next = i_pos;
      app_next = i_app;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos_reg <= `SSC_POS_RST;
      app_reg <= `SSC_APP_RST;
    end else begin
      pos_reg <= pos_next;
      app_reg <= app_next;
    end
  end

  assign o_pos = pos_reg;
  assign o_app = app_reg;
endmodule // ssc_snap

// ### tb/ssc_selectors.sv
// Rotary selector model for the configuration check bench
`timescale 1ns/1ps
module ssc_selectors (
  input wire logic i_clk,
  input wire logic [2:0] i_pos,
  input wire logic [3:0] i_app,
  input wire logic i_bump,
  output logic [2:0] o_start_sel,
  output logic [3:0] o_app_sel
);
  // Knob moves one step only while the bench bumps it
  always_ff @(posedge i_clk) begin
    o_start_sel <= i_pos + {2'h0, i_bump};
    o_app_sel <= i_app;
  end
endmodule // ssc_selectors

// ### tb/ssc_config_check_properties.sv
// Assertion checker for the configuration check
`timescale 1ns/1ps
module ssc_config_check_chk
  import ssc_pkg::*;
#(parameter logic [127:0] COMPAT = '1) (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_start_sel,
  input wire logic [3:0] i_app_sel,
  input wire ssc_cfg_s o_cfg,
  input wire logic [3:0] o_app_cfg,
  input wire logic o_cfg_valid,
  input wire logic o_cfg_err,
  input wire logic o_safe_state,
  input wire logic o_startup_done
);
  // Saturates so it never wraps into the settle window
  logic [8:0] cnt_reg;
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst) cnt_reg <= 9'h000;
    else if (cnt_reg != 9'h1ff) cnt_reg <= cnt_reg + 9'h001;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_err_sticky: assert property (o_cfg_err |=> o_cfg_err) else $error("error dropped");
  chk_err_safe: assert property (o_cfg_err |-> o_safe_state) else $error("error not safe");
  chk_cfg_hold: assert property (o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg))
    else $error("cfg moved");
  chk_sel_moved: assert property (o_cfg_valid && !$stable({i_start_sel, i_app_sel}) |=> o_cfg_err)
    else $error("move missed");
  chk_decode: assert property (o_cfg_valid && $stable(i_start_sel) |->
    o_cfg == {i_start_sel[1], i_start_sel[0], !i_start_sel[2]}) else $error("bad decode");
  chk_settle: assert property (cnt_reg < 9'h0fa |-> !o_cfg_valid && !o_cfg_err)
    else $error("early capture");
  chk_capture_time: assert property ($rose(o_cfg_valid) |-> cnt_reg == 9'h0fa)
    else $error("late capture");
  chk_startup: assert property (o_startup_done |-> !o_safe_state && o_cfg_valid)
    else $error("done while safe");
  chk_compat: assert property ($rose(o_cfg_valid) |-> COMPAT[{o_app_cfg, i_start_sel}])
    else $error("bad combination");
  cover property ($rose(o_cfg_err));
  cover property ($rose(o_startup_done));
  cover property ($rose(o_cfg_valid));
endmodule // ssc_config_check_chk
bind ssc_config_check ssc_config_check_chk #(.COMPAT(COMPAT)) i_chk (.i_clk, .i_sys_rst, .i_start_sel,
  .i_app_sel, .o_cfg, .o_app_cfg, .o_cfg_valid, .o_cfg_err, .o_safe_state, .o_startup_done);

// ### tb/ssc_config_check_bench.sv
// Self-checking bench for the configuration check
`timescale 1ns/1ps
module ssc_config_check_bench;
  import ssc_pkg::*;
  // Application 1 refuses position code 7, the last knob position
  localparam logic [127:0] COMPAT = ~(128'h1 << 15);
  logic i_clk = 0, i_sys_rst = 1, bump = 0, pv = 0, pe = 0, oerr = 0;
  logic [2:0] pos = 0, start_sel;
  logic [3:0] app = 0, app_sel, app_cfg;
  logic [1:0] safe_in = 2'b11;
  logic [31:0] seed = 32'hb739_3bce;
  logic [3:0] q[$];
  ssc_cfg_s cfg;
  logic valid, err, safe, done;
  int n_fail = 0, tests_run = 0;
  always #2 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  ssc_selectors i_sel (.i_clk, .i_pos(pos), .i_app(app), .i_bump(bump), .o_start_sel(start_sel),
    .o_app_sel(app_sel));
  ssc_config_check #(.COMPAT(COMPAT)) i_dut (.i_clk, .i_sys_rst, .i_start_sel(start_sel),
    .i_app_sel(app_sel), .i_safe_in(safe_in), .i_other_err(oerr), .o_cfg(cfg), .o_app_cfg(app_cfg),
    .o_cfg_valid(valid), .o_cfg_err(err), .o_safe_state(safe), .o_startup_done(done));
  always @(posedge i_clk) begin
    pv <= valid;
    pe <= err;
    if ((valid && !pv) || (err && !pe)) begin
      if (q.size() == 0) cmp(4'hf, 4'h0);
      else cmp({cfg, err}, q.pop_front());
    end
  end
  initial begin
    logic [2:0] p;
    logic mon, tst, bad;
    for (int i = 0; i < 9; i++) begin
      cyc(1);
      seed = lfsr(seed);
      p = (i == 8) ? 3'h7 : i[2:0];
      pos <= p;
      app <= (i == 8) ? 4'h1 : seed[3:0];
      i_sys_rst <= 1;
      cyc((i == 0) ? 11 : 12);
      i_sys_rst <= 0;
      mon = p inside {3'h2, 3'h3, 3'h6, 3'h7};
      tst = p inside {3'h1, 3'h3, 3'h5, 3'h7};
      bad = !COMPAT[{((i == 8) ? 4'h1 : seed[3:0]), p}];
      q.push_back({mon, tst, p < 3'h4, bad});
      for (int k = 0; k < 300 && !(valid || err); k++) @(negedge i_clk);
      if (!(valid || err)) begin
        n_fail++;
        test_done();
      end
      cmp(app_cfg, app);
      if (!bad) begin
        cmp({3'h0, done}, {3'h0, !tst});
        cyc(1);
        safe_in <= 2'b10;
        cyc(2);
        safe_in <= 2'b01;
        cyc(2);
        safe_in <= 2'b11;
        cyc(3);
        @(negedge i_clk);
        cmp({2'h0, done, safe}, 4'h2);
        cyc(1);
        if (i == 3) begin
          // Other fault: safe state with no configuration error
          oerr <= 1;
          cyc(2);
          @(negedge i_clk);
          cmp({1'h0, valid, err, safe}, 4'h1);
          cyc(1);
          oerr <= 0;
        end
        q.push_back({mon, tst, p < 3'h4, 1'b1});
        bump <= 1;
        cyc(1);
        bump <= 0;
      end
      // Knob is back in place here, so a cleared flag would show
      cyc(5);
      @(negedge i_clk);
      cmp({2'h0, err, safe}, 4'h3);
    end
    cmp({3'h0, q.size() == 0}, 4'h1);
    test_done();
  end
endmodule // ssc_config_check_bench
